// [pkg/sra_map.svh]
`ifndef SRA_MAP_SVH
`define SRA_MAP_SVH
// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SRA_OP_REG_READ 8'h97
`define SRA_OP_REG_WRITE 8'hD2
`define SRA_OP_REG_STATUS 8'hAD
`define SRA_OP_CHAN_SWITCH 8'hB0
`define SRA_OP_SENS_XFER 8'hA6
`define SRA_OP_SENS_STATUS 8'hF5
// ----------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------
`define SRA_ST_ERROR 7
`define SRA_ST_REFUSED 3
`define SRA_ST_FAIL 2
`define SRA_ST_BUSY 1
`define SRA_ST_VALID 0
`define SRA_SENSOR_VALID_BIT_POS 7
// ----------------------------------------------------------------
// Channel switch data byte and reset values
// ----------------------------------------------------------------
`define SRA_ACT_REG_POS 1
`define SRA_ACT_SENS_POS 0
`define SRA_CHAN_RST 1'b1
`define SRA_SENS_BYTES 2
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SRA_SYS_CLK_NS 20
`define SRA_SCLK_HALF_NS 200
`define SRA_SCLK_HALF_CYC ((`SRA_SCLK_HALF_NS + `SRA_SYS_CLK_NS - 1) / `SRA_SYS_CLK_NS)
`define SRA_POLL_MAX 16
`endif

// [pkg/sra_pkg.sv]
package sra_pkg;
	typedef enum logic [2:0] {
		SRA_PH_OPCODE, SRA_PH_ECHO, SRA_PH_STATUS, SRA_PH_DATA, SRA_PH_SVAL, SRA_PH_SENS, SRA_PH_SWITCH, SRA_PH_PASS
	} sra_phase_t;
	typedef enum logic [2:0] {
		SRA_H_IDLE, SRA_H_SEL, SRA_H_HIGH, SRA_H_LOW, SRA_H_DESEL, SRA_H_GAP
	} sra_hstate_t;
endpackage : sra_pkg

// [pkg/sra_if.sv]
`timescale 1ns/100ps
interface sra_if;
	logic ncs;
	logic sclk;
	logic mosi;
	logic miso;
	modport dev (input ncs, input sclk, input mosi, output miso);
	modport host (output ncs, output sclk, output mosi, input miso);
endinterface : sra_if

// [src/sra_dev.sv]
`timescale 1ns/100ps
`include "sra_map.svh"
// What this block does
// - Read: opcode, address, both echoed on MISO.
// - Write: opcode, address, data, all echoed.
// - Master polls status/data until data valid.
// - Master polls status/data until write finished.
// - Status/data: echo opcode, send status, data.
// - Status bits: refused, failed, busy, valid.
// - Error bit 7 reflects only last transfer.
// - Register access refreshes all but error.
// - Valid bit qualifies the status/data byte.
// - Data byte: read value or written byte.
// - Sensor valid bit sits at bit 7.
// - Sensor data ready with no processing delay.
// - Master checks status/data after sensor transfer.
// - Opcodes 0x97, 0xD2, 0xAD as first byte.
// - Modes 0/3, rising sample, 8-bit MSB first.
// - Register channel off: error, pass MOSI through.
// - Channel switch clears four register status bits.
module sra_dev import sra_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Link
	sra_if.dev spi,
	// Register access port
	output logic reg_req,
	output logic reg_we,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic reg_ack,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_refused,
	input wire logic reg_fail,
	// Sensor port
	input wire logic [`SRA_SENS_BYTES*8-1:0] sensor_data,
	input wire logic sensor_ok,
	// Channel state
	output logic register_channel_on,
	output logic sensor_channel_on
);
	// ----------------------------------------------------------------
	// Pin synchronisers and SCLK edge detection
	// ----------------------------------------------------------------
	logic [1:0] ncs_q, mosi_q;
	logic [2:0] sclk_q;
	logic sel_d, sel, frame_start, frame_end, sclk_rise, sclk_fall, byte_done;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ncs_q <= 2'h3;
			sclk_q <= 3'h0;
			mosi_q <= 2'h0;
			sel_d <= 1'b0;
		end else begin
			ncs_q <= {ncs_q[0], spi.ncs};
			sclk_q <= {sclk_q[1:0], spi.sclk};
			mosi_q <= {mosi_q[0], spi.mosi};
			sel_d <= ~ncs_q[1];
		end
	end
	assign sel = ~ncs_q[1];
	assign frame_start = sel & ~sel_d;
	assign frame_end = ~sel & sel_d;
	assign sclk_rise = sel & sclk_q[1] & ~sclk_q[2];
	assign sclk_fall = sel & ~sclk_q[1] & sclk_q[2];
	// ----------------------------------------------------------------
	// Bit and byte framing
	// ----------------------------------------------------------------
	logic [2:0] bit_cnt_r, byte_cnt_r;
	logic [7:0] rx_r, rx_byte, op_r, tx_r, data_r, addr_r, status_byte;
	assign rx_byte = {rx_r[6:0], mosi_q[1]};
	assign byte_done = sclk_rise & (bit_cnt_r == 3'h7);
	always_ff @(posedge sys_clk) begin
		if (rst || frame_start) begin
			bit_cnt_r <= 3'h0;
			byte_cnt_r <= 3'h0;
			rx_r <= 8'h00;
		end else if (sclk_rise) begin
			rx_r <= rx_byte;
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (byte_done && byte_cnt_r != 3'h7) begin
				byte_cnt_r <= byte_cnt_r + 3'h1;
			end
		end
	end
	// ----------------------------------------------------------------
	// Command phase and output shifter
	// ----------------------------------------------------------------
	sra_phase_t phase_r;
	logic frame_err_r, error_r;
	logic busy_r, valid_r, fail_r, refused_r, sens_ok_r;
	logic [`SRA_SENS_BYTES*8-1:0] sens_r;
	// Reserved bits 6 to 4 are tied low.
	assign status_byte = {error_r, 3'h0, refused_r, fail_r, busy_r, valid_r};
	logic issue, issue_we, clr_flags;
	assign issue = byte_done && (phase_r == SRA_PH_ECHO) && ((op_r == `SRA_OP_REG_READ && byte_cnt_r == 3'h1)
		|| (op_r == `SRA_OP_REG_WRITE && byte_cnt_r == 3'h2));
	assign issue_we = (op_r == `SRA_OP_REG_WRITE);
	always_ff @(posedge sys_clk) begin
		if (rst || frame_start) begin
			phase_r <= SRA_PH_OPCODE;
			op_r <= 8'h00;
			tx_r <= 8'h00;
			frame_err_r <= 1'b0;
		end else if (byte_done) begin
			case (phase_r)
				SRA_PH_OPCODE: begin
					op_r <= rx_byte;
					phase_r <= SRA_PH_PASS;
					if (rx_byte == `SRA_OP_REG_READ || rx_byte == `SRA_OP_REG_WRITE) begin
						if (register_channel_on) begin
							phase_r <= SRA_PH_ECHO;
						end else begin
							frame_err_r <= 1'b1;
						end
					end else if (rx_byte == `SRA_OP_REG_STATUS) begin
						if (register_channel_on) begin
							phase_r <= SRA_PH_STATUS;
							tx_r <= status_byte;
						end else begin
							frame_err_r <= 1'b1;
						end
					end else if (rx_byte == `SRA_OP_SENS_XFER) begin
						if (!sensor_channel_on) begin
							frame_err_r <= 1'b1;
						end else begin
							phase_r <= SRA_PH_SENS;
							tx_r <= sens_ok_r ? sens_r[`SRA_SENS_BYTES*8-1 -: 8] : 8'h00;
							frame_err_r <= ~sens_ok_r;
						end
					end else if (rx_byte == `SRA_OP_SENS_STATUS) begin
						if (!sensor_channel_on) begin
							frame_err_r <= 1'b1;
						end else begin
							phase_r <= SRA_PH_SVAL;
							tx_r <= {sens_ok_r, 7'h00};
						end
					end else if (rx_byte == `SRA_OP_CHAN_SWITCH) begin
						phase_r <= SRA_PH_SWITCH;
					end else begin
						frame_err_r <= 1'b1;
					end
				end
				SRA_PH_STATUS: begin
					phase_r <= SRA_PH_DATA;
					tx_r <= data_r;
				end
				SRA_PH_SENS: begin
					if (byte_cnt_r == 3'(`SRA_SENS_BYTES)) begin
						phase_r <= SRA_PH_PASS;
					end else begin
						tx_r <= sens_ok_r ? sens_r[(`SRA_SENS_BYTES - 32'(byte_cnt_r)) * 8 - 1 -: 8] : 8'h00;
					end
				end
				SRA_PH_ECHO: begin
					if (issue) begin
						phase_r <= SRA_PH_PASS;
					end
				end
				default: begin
					phase_r <= SRA_PH_PASS;
				end
			endcase
		end else if (sclk_fall && bit_cnt_r != 3'h0) begin
			tx_r <= {tx_r[6:0], 1'b0};
		end
	end
	// The error flag is taken over only when the frame closes.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			error_r <= 1'b0;
		end else if (frame_end) begin
			error_r <= frame_err_r;
		end
	end
	// Sensor word is latched on the first rising edge of every frame.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sens_r <= '0;
			sens_ok_r <= 1'b0;
		end else if (sclk_rise && bit_cnt_r == 3'h0 && byte_cnt_r == 3'h0) begin
			sens_r <= sensor_data;
			sens_ok_r <= sensor_ok;
		end
	end
	// ----------------------------------------------------------------
	// MISO driver
	// ----------------------------------------------------------------
	logic shifting, miso_r;
	assign shifting = phase_r == SRA_PH_STATUS || phase_r == SRA_PH_DATA || phase_r == SRA_PH_SENS
		|| phase_r == SRA_PH_SVAL;
	always_ff @(posedge sys_clk) begin
		if (rst || !sel) begin
			miso_r <= 1'b1;
		end else if (shifting) begin
			miso_r <= tx_r[7];
		end else begin
			miso_r <= mosi_q[1];
		end
	end
	assign spi.miso = miso_r;
	// ----------------------------------------------------------------
	// Register channel and status flags
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			register_channel_on <= `SRA_CHAN_RST;
			sensor_channel_on <= `SRA_CHAN_RST;
		end else if (byte_done && phase_r == SRA_PH_SWITCH) begin
			register_channel_on <= rx_byte[`SRA_ACT_REG_POS];
			sensor_channel_on <= rx_byte[`SRA_ACT_SENS_POS];
		end
	end
	assign clr_flags = byte_done && phase_r == SRA_PH_OPCODE && rx_byte == `SRA_OP_CHAN_SWITCH;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busy_r <= 1'b0;
			valid_r <= 1'b0;
			fail_r <= 1'b0;
			refused_r <= 1'b0;
			data_r <= 8'h00;
			reg_req <= 1'b0;
			reg_we <= 1'b0;
			reg_addr <= 8'h00;
			reg_wdata <= 8'h00;
			addr_r <= 8'h00;
		end else begin
			reg_req <= 1'b0;
			if (clr_flags) begin
				busy_r <= 1'b0;
				valid_r <= 1'b0;
				fail_r <= 1'b0;
				refused_r <= 1'b0;
			end
			if (byte_done && phase_r == SRA_PH_ECHO && byte_cnt_r == 3'h1) begin
				addr_r <= rx_byte;
			end
			// An ack in the same cycle as a clear keeps its result.
			if (reg_ack && busy_r) begin
				busy_r <= 1'b0;
				refused_r <= reg_refused;
				fail_r <= reg_fail;
				valid_r <= ~reg_refused & ~reg_fail;
				if (!reg_we) begin
					data_r <= reg_rdata;
				end
			end else if (issue && busy_r) begin
				fail_r <= 1'b1;
				valid_r <= 1'b0;
			end else if (issue) begin
				reg_req <= 1'b1;
				reg_we <= issue_we;
				if (op_r == `SRA_OP_REG_READ) begin
					reg_addr <= rx_byte;
				end else begin
					reg_addr <= addr_r;
					reg_wdata <= rx_byte;
					data_r <= rx_byte;
				end
				busy_r <= 1'b1;
				valid_r <= 1'b0;
				fail_r <= 1'b0;
				refused_r <= 1'b0;
			end
		end
	end
endmodule : sra_dev

// [src/sra_host.sv]
`timescale 1ns/100ps
`include "sra_map.svh"
module sra_host import sra_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Link
	sra_if.host spi,
	// Command port
	input wire logic start,
	input wire logic [7:0] op,
	input wire logic [7:0] arg1,
	input wire logic [7:0] arg2,
	input wire logic [1:0] nbytes,
	input wire logic auto_poll,
	// Results
	output logic busy,
	output logic done,
	output logic [7:0] rx_byte0,
	output logic [7:0] rx_byte1,
	output logic [7:0] rx_byte2,
	output logic poll_timeout
);
	localparam logic [4:0] HALF = 5'(`SRA_SCLK_HALF_CYC);
	// ----------------------------------------------------------------
	// MISO synchroniser
	// ----------------------------------------------------------------
	logic [1:0] miso_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			miso_q <= 2'h3;
		end else begin
			miso_q <= {miso_q[0], spi.miso};
		end
	end
	// ----------------------------------------------------------------
	// Frame sequencer, SCLK made by division of sys_clk
	// ----------------------------------------------------------------
	sra_hstate_t st_r;
	logic [4:0] tmr_r, bits_r;
	logic [23:0] tx_r, rx_r;
	logic [1:0] nb_r;
	logic [7:0] first_op_r;
	logic poll_r, auto_r;
	logic [4:0] poll_cnt_r;
	logic ncs_r, sclk_r;
	logic [7:0] b0, b1, b2;
	always_comb begin
		b0 = 8'h00;
		b1 = 8'h00;
		b2 = rx_r[7:0];
		if (nb_r == 2'h3) begin
			b0 = rx_r[23:16];
			b1 = rx_r[15:8];
		end else if (nb_r == 2'h2) begin
			b0 = rx_r[15:8];
			b1 = rx_r[7:0];
			b2 = 8'h00;
		end else begin
			b0 = rx_r[7:0];
			b2 = 8'h00;
		end
	end
	logic poll_more;
	always_comb begin
		poll_more = 1'b0;
		if (!poll_r) begin
			poll_more = first_op_r == `SRA_OP_REG_READ || first_op_r == `SRA_OP_REG_WRITE
				|| first_op_r == `SRA_OP_SENS_XFER;
		end else if (first_op_r == `SRA_OP_REG_READ) begin
			poll_more = ~b1[`SRA_ST_VALID] & ~b1[`SRA_ST_FAIL] & ~b1[`SRA_ST_REFUSED];
		end else if (first_op_r == `SRA_OP_REG_WRITE) begin
			poll_more = b1[`SRA_ST_BUSY];
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= SRA_H_IDLE;
			tmr_r <= 5'h0;
			bits_r <= 5'h0;
			tx_r <= 24'h0;
			rx_r <= 24'h0;
			nb_r <= 2'h1;
			first_op_r <= 8'h00;
			poll_r <= 1'b0;
			auto_r <= 1'b0;
			poll_cnt_r <= 5'h0;
			ncs_r <= 1'b1;
			sclk_r <= 1'b0;
			done <= 1'b0;
			poll_timeout <= 1'b0;
			rx_byte0 <= 8'h00;
			rx_byte1 <= 8'h00;
			rx_byte2 <= 8'h00;
		end else begin
			done <= 1'b0;
			tmr_r <= tmr_r - 5'h1;
			case (st_r)
				SRA_H_IDLE: begin
					if (start) begin
						// Shorter commands are left-aligned so the opcode leads.
						tx_r <= {op, arg1, arg2};
						nb_r <= (nbytes == 2'h0) ? 2'h1 : nbytes;
						bits_r <= (nbytes == 2'h0) ? 5'd8 : {nbytes, 3'h0};
						first_op_r <= op;
						poll_r <= 1'b0;
						auto_r <= auto_poll;
						poll_cnt_r <= 5'h0;
						poll_timeout <= 1'b0;
						ncs_r <= 1'b0;
						tmr_r <= HALF;
						st_r <= SRA_H_SEL;
					end
				end
				SRA_H_SEL, SRA_H_LOW: begin
					if (tmr_r == 5'h1) begin
						sclk_r <= 1'b1;
						rx_r <= {rx_r[22:0], miso_q[1]};
						tmr_r <= HALF;
						st_r <= SRA_H_HIGH;
					end
				end
				SRA_H_HIGH: begin
					if (tmr_r == 5'h1) begin
						sclk_r <= 1'b0;
						tx_r <= {tx_r[22:0], 1'b0};
						bits_r <= bits_r - 5'h1;
						tmr_r <= HALF;
						st_r <= (bits_r == 5'h1) ? SRA_H_DESEL : SRA_H_LOW;
					end
				end
				SRA_H_DESEL: begin
					if (tmr_r == 5'h1) begin
						ncs_r <= 1'b1;
						tmr_r <= HALF;
						st_r <= SRA_H_GAP;
					end
				end
				default: begin
					if (tmr_r == 5'h1) begin
						if (auto_r && poll_more && poll_cnt_r != 5'(`SRA_POLL_MAX)) begin
							tx_r <= {`SRA_OP_REG_STATUS, 16'hFFFF};
							nb_r <= 2'h3;
							bits_r <= 5'd24;
							poll_r <= 1'b1;
							poll_cnt_r <= poll_cnt_r + 5'h1;
							ncs_r <= 1'b0;
							tmr_r <= HALF;
							st_r <= SRA_H_SEL;
						end else begin
							poll_timeout <= auto_r & poll_more;
							rx_byte0 <= b0;
							rx_byte1 <= b1;
							rx_byte2 <= b2;
							done <= 1'b1;
							st_r <= SRA_H_IDLE;
						end
					end
				end
			endcase
		end
	end
	assign busy = (st_r != SRA_H_IDLE);
	assign spi.ncs = ncs_r;
	assign spi.sclk = sclk_r;
	assign spi.mosi = tx_r[23];
endmodule : sra_host

// [tb/sra_monitor.sv]
`timescale 1ns/100ps
`include "sra_map.svh"
module sra_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Link
	input wire logic ncs,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso
);
	logic sclk_r;
	logic [5:0] cnt_r;
	logic [7:0] sh_r;
	logic [7:0] op_r;
	logic rise;
	logic echo;
	assign rise = sclk & ~sclk_r;
	// Answer bytes of status and sensor commands are not echoes, so they are left out here.
	assign echo = cnt_r < 6'h08 || !(op_r inside {`SRA_OP_REG_STATUS, `SRA_OP_SENS_XFER, `SRA_OP_SENS_STATUS});
	always_ff @(posedge sys_clk) begin
		sclk_r <= sclk;
	end
	always_ff @(posedge sys_clk) begin
		if (rst || ncs) begin
			cnt_r <= 6'h00;
			sh_r <= 8'h00;
		end else if (rise) begin
			cnt_r <= cnt_r + 6'h01;
			sh_r <= {sh_r[6:0], mosi};
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			op_r <= 8'h00;
		end else if (rise && cnt_r == 6'h07) begin
			op_r <= {sh_r[6:0], mosi};
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	a_miso_idle_high: assert property (ncs [*6] |-> miso)
		else $error("miso not high while deselected");
	a_sclk_idle_low: assert property (ncs |-> !sclk)
		else $error("sclk not low while deselected");
	a_sclk_high_time: assert property ($rose(sclk) |-> sclk [*8])
		else $error("sclk high phase too short");
	a_mosi_held_high: assert property (sclk |-> $stable(mosi))
		else $error("mosi moved while sclk high");
	a_echo_on_miso: assert property (rise && echo |-> miso == mosi)
		else $error("miso does not echo mosi");
	a_reserved_bits_zero: assert property (rise && op_r == `SRA_OP_REG_STATUS && cnt_r inside {[9:11]} |-> !miso)
		else $error("reserved status bit not zero");
	a_sensor_low_zero: assert property (rise && op_r == `SRA_OP_SENS_STATUS && cnt_r inside {[9:15]} |-> !miso)
		else $error("sensor status low bits not zero");
	a_whole_bytes: assert property ($rose(ncs) |-> cnt_r[2:0] == 3'h0 && cnt_r != 6'h00)
		else $error("frame not whole bytes");
	a_clock_after_select: assert property ($fell(ncs) |-> ##[8:12] sclk)
		else $error("no sclk after select");
endmodule : sra_monitor

// [tb/test_spi_register_access_commands.sv]
`timescale 1ns/100ps
`include "sra_map.svh"
`define CK(what, exp, got) \
	begin \
		checked++; \
		if ((got) !== (exp)) begin \
			fail_count++; \
			$display("[FAIL] %s expected %h seen %h", what, exp, got); \
		end \
	end
module test_spi_register_access_commands;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic [7:0] op = 8'h00;
	logic [7:0] arg1 = 8'h00;
	logic [7:0] arg2 = 8'h00;
	logic [1:0] nbytes = 2'h1;
	logic auto_poll = 1'b0;
	logic busy, done, poll_timeout, reg_req, reg_we, reg_on, sens_on;
	logic [7:0] rx0, rx1, rx2, reg_addr, reg_wdata;
	logic reg_ack = 1'b0;
	logic reg_refused = 1'b0;
	logic reg_fail = 1'b0;
	logic [7:0] reg_rdata = 8'h00;
	logic [7:0] last_addr = 8'h00;
	logic [15:0] sensor_data = 16'hBEEF;
	logic sensor_ok = 1'b1;
	logic [7:0] mem [256];
	int ack_delay = 3;
	int wait_cnt = 0;
	int req_count = 0;
	int cycles = 0;
	int fail_count = 0;
	int checked = 0;
	sra_if sra_if_inst ();
	sra_dev sra_dev_inst (.sys_clk(sys_clk), .rst(rst), .spi(sra_if_inst.dev), .reg_req(reg_req), .reg_we(reg_we),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
		.reg_refused(reg_refused), .reg_fail(reg_fail), .sensor_data(sensor_data), .sensor_ok(sensor_ok),
		.register_channel_on(reg_on), .sensor_channel_on(sens_on));
	sra_host sra_host_inst (.sys_clk(sys_clk), .rst(rst), .spi(sra_if_inst.host), .start(start), .op(op),
		.arg1(arg1), .arg2(arg2), .nbytes(nbytes), .auto_poll(auto_poll), .busy(busy), .done(done),
		.rx_byte0(rx0), .rx_byte1(rx1), .rx_byte2(rx2), .poll_timeout(poll_timeout));
	sra_monitor sra_monitor_inst (.sys_clk(sys_clk), .rst(rst), .ncs(sra_if_inst.ncs), .sclk(sra_if_inst.sclk),
		.mosi(sra_if_inst.mosi), .miso(sra_if_inst.miso));
	always #10 sys_clk = ~sys_clk;
	// ----------------------------------------
	// Register file behind the device
	// ----------------------------------------
	// The ack delay is a knob so that a status poll can land while a request is still open.
	always @(negedge sys_clk) begin
		reg_ack <= 1'b0;
		if (reg_req === 1'b1) begin
			req_count <= req_count + 1;
			last_addr <= reg_addr;
			wait_cnt <= ack_delay;
		end else if (wait_cnt > 0) begin
			wait_cnt <= wait_cnt - 1;
			if (wait_cnt == 1) begin
				reg_ack <= 1'b1;
				reg_rdata <= mem[last_addr];
				if (reg_we === 1'b1)
					mem[last_addr] <= reg_wdata;
			end
		end
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic cmd(input logic [7:0] o, input logic [7:0] a1 = 8'h00, input logic [7:0] a2 = 8'h00,
		input logic [1:0] n = 2'h3, input logic ap = 1'b0);
		int k;
		k = 0;
		@(negedge sys_clk);
		op = o;
		arg1 = a1;
		arg2 = a2;
		nbytes = n;
		auto_poll = ap;
		start = 1'b1;
		@(negedge sys_clk);
		start = 1'b0;
		`CK("busy", 1'b1, busy)
		while (done !== 1'b1 && k < 20000) begin
			@(negedge sys_clk);
			k++;
		end
		`CK("done", 1'b1, done)
	endtask : cmd
	task automatic exp3(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
		`CK("rx_byte0", e0, rx0)
		`CK("rx_byte1", e1, rx1)
		`CK("rx_byte2", e2, rx2)
	endtask : exp3
	task automatic status(input logic [7:0] e);
		cmd(`SRA_OP_REG_STATUS);
		`CK("status", e, rx1)
	endtask : status
	task automatic err(input logic e);
		cmd(`SRA_OP_REG_STATUS);
		`CK("error", e, rx1[`SRA_ST_ERROR])
	endtask : err
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_read();
		mem[8'h3C] = 8'h5A;
		cmd(`SRA_OP_REG_READ, 8'h3C, , 2'h2);
		exp3(`SRA_OP_REG_READ, 8'h3C, 8'h00);
		`CK("reg_addr", 8'h3C, last_addr)
		cmd(`SRA_OP_REG_STATUS);
		exp3(`SRA_OP_REG_STATUS, 8'h01, 8'h5A);
	endtask : t_read
	task automatic t_write();
		cmd(`SRA_OP_REG_WRITE, 8'h41, 8'hC3);
		exp3(`SRA_OP_REG_WRITE, 8'h41, 8'hC3);
		cmd(`SRA_OP_REG_STATUS);
		exp3(`SRA_OP_REG_STATUS, 8'h01, 8'hC3);
		`CK("mem", 8'hC3, mem[8'h41])
		cmd(`SRA_OP_REG_WRITE, 8'h42, 8'h7E, 2'h3, 1'b1);
		exp3(`SRA_OP_REG_STATUS, 8'h01, 8'h7E);
	endtask : t_write
	task automatic t_flags();
		reg_refused = 1'b1;
		cmd(`SRA_OP_REG_READ, 8'h10, , 2'h2);
		status(8'h08);
		reg_refused = 1'b0;
		reg_fail = 1'b1;
		cmd(`SRA_OP_REG_READ, 8'h10, , 2'h2);
		status(8'h04);
		reg_fail = 1'b0;
	endtask : t_flags
	task automatic t_busy();
		int k;
		k = 0;
		ack_delay = 2500;
		cmd(`SRA_OP_REG_READ, 8'h3C, , 2'h2);
		status(8'h02);
		cmd(`SRA_OP_REG_READ, 8'h3C, , 2'h2);
		status(8'h06);
		while (reg_ack !== 1'b1 && k < 2000) begin
			@(negedge sys_clk);
			k++;
		end
		status(8'h01);
		cmd(`SRA_OP_REG_READ, 8'h3C, , 2'h2, 1'b1);
		exp3(`SRA_OP_REG_STATUS, 8'h01, 8'h5A);
		`CK("poll_timeout", 1'b0, poll_timeout)
		ack_delay = 3;
	endtask : t_busy
	task automatic t_error();
		cmd(8'h55, , , 2'h1);
		`CK("rx_byte0", 8'h55, rx0)
		err(1'b1);
		err(1'b0);
	endtask : t_error
	task automatic t_sensor();
		cmd(`SRA_OP_SENS_XFER);
		exp3(`SRA_OP_SENS_XFER, 8'hBE, 8'hEF);
		sensor_data = 16'h1234;
		cmd(`SRA_OP_SENS_XFER);
		exp3(`SRA_OP_SENS_XFER, 8'h12, 8'h34);
		err(1'b0);
		cmd(`SRA_OP_SENS_STATUS, , , 2'h2);
		exp3(`SRA_OP_SENS_STATUS, 8'h80, 8'h00);
		sensor_ok = 1'b0;
		cmd(`SRA_OP_SENS_XFER);
		exp3(`SRA_OP_SENS_XFER, 8'h00, 8'h00);
		err(1'b1);
		cmd(`SRA_OP_SENS_STATUS, , , 2'h2);
		exp3(`SRA_OP_SENS_STATUS, 8'h00, 8'h00);
		sensor_ok = 1'b1;
	endtask : t_sensor
	task automatic t_channel();
		int n;
		cmd(`SRA_OP_REG_READ, 8'h3C, , 2'h2);
		cmd(`SRA_OP_CHAN_SWITCH, 8'h01, , 2'h2);
		`CK("reg_on", 1'b0, reg_on)
		`CK("sens_on", 1'b1, sens_on)
		n = req_count;
		cmd(`SRA_OP_REG_READ, 8'h3C, , 2'h2);
		exp3(`SRA_OP_REG_READ, 8'h3C, 8'h00);
		cmd(`SRA_OP_REG_STATUS, 8'h81, 8'h99);
		exp3(`SRA_OP_REG_STATUS, 8'h81, 8'h99);
		`CK("requests", n, req_count)
		cmd(`SRA_OP_CHAN_SWITCH, 8'h02, , 2'h2);
		`CK("sens_on", 1'b0, sens_on)
		cmd(`SRA_OP_SENS_XFER, 8'h5A, 8'hA5);
		exp3(`SRA_OP_SENS_XFER, 8'h5A, 8'hA5);
		err(1'b1);
		cmd(`SRA_OP_CHAN_SWITCH, 8'h03, , 2'h2);
		`CK("reg_on", 1'b1, reg_on)
		status(8'h00);
	endtask : t_channel
	initial begin
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
		repeat (3) @(negedge sys_clk);
		t_read();
		t_write();
		t_flags();
		t_busy();
		t_error();
		t_sensor();
		t_channel();
		final_report();
	end
endmodule : test_spi_register_access_commands
